// ===== rtl/lcm_pkg.sv
package lcm_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_MHZ       = 200;
	localparam int MEAS_PFM_US   = 50;
	localparam int MEAS_PWM_US   = 4;
	localparam int MEAS_PFM_CYC  = MEAS_PFM_US * CLK_MHZ;
	localparam int MEAS_PWM_CYC  = MEAS_PWM_US * CLK_MHZ;
	localparam int SW_FREQ_KHZ   = 3000;
	localparam int SW_PERIOD_CYC = CLK_MHZ * 1000 / SW_FREQ_KHZ;
	localparam int DITHER_PCT    = 5;
	localparam int DITHER_CYC    = SW_PERIOD_CYC * DITHER_PCT / 100;

	////////////////////////////////////////////////////////////////////////////////
	// Sizes and scaling
	localparam int NUM_CORES = 4;
	localparam int RESULT_W  = 10;
	localparam int MA_W      = 15;
	localparam int RATE_W    = 12;
	localparam int LSB_MA    = 20;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] ADDR_CORE_SEL    = 8'h00;
	localparam logic [7:0] ADDR_RESULT_LOW  = 8'h01;
	localparam logic [7:0] ADDR_RESULT_HIGH = 8'h02;
	localparam logic [7:0] ADDR_INT_FLAG    = 8'h03;
	localparam logic [7:0] ADDR_INT_MASK    = 8'h04;
	localparam logic [7:0] ADDR_CONFIG      = 8'h05;
	localparam logic [7:0] ADDR_FIXED_FREQ  = 8'h06;
	localparam logic [7:0] ADDR_RAMP_01     = 8'h07;
	localparam logic [7:0] ADDR_RAMP_23     = 8'h08;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions and reset values
	localparam int MEAS_READY_BIT = 0;
	localparam int DITHER_EN_BIT  = 0;
	localparam int RAMP_LO_LSB    = 0;
	localparam int RAMP_HI_LSB    = 4;
	localparam logic [1:0] CORE_SEL_RST  = 2'h0;
	localparam logic       INT_MASK_RST  = 1'h0;
	localparam logic       DITHER_RST    = 1'h0;
	localparam logic [3:0] FIXED_RST     = 4'h0;
	localparam logic [2:0] RAMP_RST      = 3'h0;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_MEASURE = 2'b01,
		ST_LATCH   = 2'b10,
		ST_FLAG    = 2'b11
	} meas_state_t;

	// Ramp rate in units of 0.01 mV/us
	function automatic logic [RATE_W-1:0] ramp_rate_decode(input logic [2:0] code);
		case (code)
			3'h0:    ramp_rate_decode = 12'hbb8;
			3'h1:    ramp_rate_decode = 12'h5dc;
			3'h2:    ramp_rate_decode = 12'h3e8;
			3'h3:    ramp_rate_decode = 12'h2ee;
			3'h4:    ramp_rate_decode = 12'h17c;
			3'h5:    ramp_rate_decode = 12'h0be;
			3'h6:    ramp_rate_decode = 12'h05e;
			default: ramp_rate_decode = 12'h028;
		endcase
	endfunction : ramp_rate_decode

	function automatic logic [MA_W-1:0] scale_ma(input logic [RESULT_W-1:0] r);
		scale_ma = MA_W'(r) * MA_W'(LSB_MA);
	endfunction : scale_ma

endpackage : lcm_pkg

// ===== rtl/ramp_rate_table.sv
module ramp_rate_table (
	input  wire logic                                    i_clk,
	input  wire logic                                    i_sys_rst,
	input  wire logic [3:0][2:0]                         i_code,
	output logic      [3:0][lcm_pkg::RATE_W-1:0]         o_rate
);

	logic [3:0][lcm_pkg::RATE_W-1:0] rate_r;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rate_r <= '0;
		end else begin
			for (int k = 0; k < 4; k++) begin
				rate_r[k] <= lcm_pkg::ramp_rate_decode(i_code[k]);
			end
		end
	end

	assign o_rate = rate_r;

	// The table still shows its reset zeros one edge after release, so skip that edge
	a_ramp_fastest: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_code[0] == 3'h0) && !$past(i_sys_rst) |=> (o_rate[0] == 12'hbb8))
		else $error("ramp code 0 not decoded to fastest rate");

endmodule : ramp_rate_table

// ===== rtl/phase_interleaver.sv
module phase_interleaver #(
	parameter int PERIOD = lcm_pkg::SW_PERIOD_CYC,
	parameter int DITHER = lcm_pkg::DITHER_CYC
) (
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_dither_en,
	output logic      [3:0] o_phase_start
);

	if (PERIOD < 8 || PERIOD > 120 || DITHER * 4 >= PERIOD) begin : g_chk
		$error("phase_interleaver: period or dither out of range");
	end

	localparam logic [6:0] P_NOM = 7'(PERIOD);
	localparam logic [6:0] P_MIN = 7'(PERIOD - DITHER);
	localparam int         SPAN  = 2 * DITHER + 1;

	logic [6:0] cnt_r;
	logic [6:0] period_r;
	logic [7:0] lfsr_r;
	logic [3:0] start_r;

	wire logic       wrap    = (cnt_r == period_r - 7'h01);
	wire logic [6:0] quarter = period_r >> 2;
	wire logic [6:0] dith_p  = P_MIN + 7'(lfsr_r % 8'(SPAN));
	wire logic [7:0] lfsr_nx = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_r    <= 7'h00;
			period_r <= P_NOM;
			lfsr_r   <= 8'h01;
			start_r  <= 4'h0;
		end else begin
			lfsr_r <= lfsr_nx;
			cnt_r  <= wrap ? 7'h00 : cnt_r + 7'h01;
			// New period only at a wrap, so each cycle stays whole
			if (wrap) begin
				period_r <= i_dither_en ? dith_p : P_NOM;
			end
			for (int k = 0; k < 4; k++) begin
				start_r[k] <= (cnt_r == 7'(k) * quarter);
			end
		end
	end

	assign o_phase_start = start_r;

	a_dither_band: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(period_r >= P_MIN) && (period_r <= 7'(PERIOD + DITHER)))
		else $error("switching period left the dither band");

	a_no_dither: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(wrap && !i_dither_en) |=> (period_r == P_NOM))
		else $error("period dithered while dither disabled");

	a_quarter_step: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_phase_start[1] |-> ($past(cnt_r) == $past(quarter)))
		else $error("second core did not start a quarter period late");

endmodule : phase_interleaver

// ===== rtl/load_current_monitor.sv
module load_current_monitor #(
	parameter int MEAS_PFM_CYCLES = lcm_pkg::MEAS_PFM_CYC,
	parameter int MEAS_PWM_CYCLES = lcm_pkg::MEAS_PWM_CYC
) (
	input  wire logic                                      i_clk,
	input  wire logic                                      i_sys_rst,
	input  wire lcm_pkg::reg_req_t                         i_reg_req,
	input  wire logic      [3:0]                           i_core_light_load,
	input  wire logic      [3:0][lcm_pkg::RESULT_W-1:0]    i_core_current_code,
	output logic           [7:0]                           o_rd_data,
	output logic                                           o_interrupt_request_n,
	output logic           [3:0]                           o_core_pwm,
	output logic           [3:0]                           o_core_phase_start,
	output logic           [3:0][lcm_pkg::RATE_W-1:0]      o_ramp_rate,
	output logic           [lcm_pkg::MA_W-1:0]             o_load_current_ma,
	output logic                                           o_meas_busy
);

	localparam int TW = $clog2(MEAS_PFM_CYCLES + 1);

	if (MEAS_PWM_CYCLES < 1 || MEAS_PWM_CYCLES > MEAS_PFM_CYCLES) begin : g_chk
		$error("load_current_monitor: measurement counts out of range");
	end

	localparam logic [TW-1:0] PFM_LOAD = TW'(MEAS_PFM_CYCLES - 1);
	localparam logic [TW-1:0] PWM_LOAD = TW'(MEAS_PWM_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////////
	// State

	lcm_pkg::meas_state_t            state_r;
	lcm_pkg::meas_state_t            state_nxt;
	logic [TW-1:0]                   tmr_r;
	logic [1:0]                      core_sel_r;
	logic [lcm_pkg::RESULT_W-1:0]    result_r;
	logic                            int_flag_r;
	logic                            int_mask_r;
	logic                            dither_en_r;
	logic [3:0]                      fixed_freq_r;
	logic [3:0][2:0]                 ramp_code_r;
	logic [3:0]                      core_pwm_r;
	logic [3:0]                      core_pwm_nxt;
	logic                            irq_n_r;
	logic [7:0]                      rd_data_r;
	logic [lcm_pkg::MA_W-1:0]        ma_r;
	logic                            busy_r;

	////////////////////////////////////////////////////////////////////////////////
	// Register decode

	wire logic [7:0] addr  = i_reg_req.addr;
	wire logic [7:0] wdata = i_reg_req.wdata;

	wire logic wr_sel   = i_reg_req.wr && (addr == lcm_pkg::ADDR_CORE_SEL);
	wire logic wr_flag  = i_reg_req.wr && (addr == lcm_pkg::ADDR_INT_FLAG);
	wire logic wr_mask  = i_reg_req.wr && (addr == lcm_pkg::ADDR_INT_MASK);
	wire logic wr_cfg   = i_reg_req.wr && (addr == lcm_pkg::ADDR_CONFIG);
	wire logic wr_fixed = i_reg_req.wr && (addr == lcm_pkg::ADDR_FIXED_FREQ);
	wire logic wr_r01   = i_reg_req.wr && (addr == lcm_pkg::ADDR_RAMP_01);
	wire logic wr_r23   = i_reg_req.wr && (addr == lcm_pkg::ADDR_RAMP_23);

	wire logic launch   = wr_sel;
	wire logic flag_clr = wr_flag && wdata[lcm_pkg::MEAS_READY_BIT];
	wire logic flag_set = (state_r == lcm_pkg::ST_FLAG);

	wire logic [1:0] new_core     = wdata[1:0];
	wire logic       new_core_pwm = core_pwm_r[new_core];
	// Duration is chosen from the mode the core is in when the write lands
	wire logic [TW-1:0] tmr_load  = new_core_pwm ? PWM_LOAD : PFM_LOAD;

	wire logic [lcm_pkg::RESULT_W-1:0] cur_code = i_core_current_code[core_sel_r];
	wire logic                         measuring = (state_r == lcm_pkg::ST_MEASURE);

	wire logic [7:0] ramp01 = {1'b0, ramp_code_r[1], 1'b0, ramp_code_r[0]};
	wire logic [7:0] ramp23 = {1'b0, ramp_code_r[3], 1'b0, ramp_code_r[2]};

	wire logic [7:0] rd_mux =
		(addr == lcm_pkg::ADDR_CORE_SEL)    ? {6'h00, core_sel_r} :
		(addr == lcm_pkg::ADDR_RESULT_LOW)  ? result_r[7:0] :
		(addr == lcm_pkg::ADDR_RESULT_HIGH) ? {6'h00, result_r[9:8]} :
		(addr == lcm_pkg::ADDR_INT_FLAG)    ? {7'h00, int_flag_r} :
		(addr == lcm_pkg::ADDR_INT_MASK)    ? {7'h00, int_mask_r} :
		(addr == lcm_pkg::ADDR_CONFIG)      ? {7'h00, dither_en_r} :
		(addr == lcm_pkg::ADDR_FIXED_FREQ)  ? {4'h0, fixed_freq_r} :
		(addr == lcm_pkg::ADDR_RAMP_01)     ? ramp01 :
		(addr == lcm_pkg::ADDR_RAMP_23)     ? ramp23 : 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Core mode selection

	for (genvar k = 0; k < 4; k++) begin : g_mode
		// Forcing during measurement keeps the sense path in fixed frequency
		assign core_pwm_nxt[k] = fixed_freq_r[k] || !i_core_light_load[k]
			|| (measuring && core_sel_r == 2'(k));
	end

	////////////////////////////////////////////////////////////////////////////////
	// Measurement sequencer

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			lcm_pkg::ST_IDLE:    state_nxt = lcm_pkg::ST_IDLE;
			lcm_pkg::ST_MEASURE: begin
				if (tmr_r == '0) begin
					state_nxt = lcm_pkg::ST_LATCH;
				end
			end
			lcm_pkg::ST_LATCH:   state_nxt = lcm_pkg::ST_FLAG;
			lcm_pkg::ST_FLAG:    state_nxt = lcm_pkg::ST_IDLE;
			default:             state_nxt = lcm_pkg::ST_IDLE;
		endcase
		// A fresh write always restarts, even mid-sequence
		if (launch) begin
			state_nxt = lcm_pkg::ST_MEASURE;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_r    <= lcm_pkg::ST_IDLE;
			tmr_r      <= '0;
			core_sel_r <= lcm_pkg::CORE_SEL_RST;
		end else begin
			state_r <= state_nxt;
			if (launch) begin
				tmr_r      <= tmr_load;
				core_sel_r <= new_core;
			end else if (measuring && tmr_r != '0) begin
				tmr_r <= tmr_r - TW'(1);
			end
		end
	end

	// Result only moves on completion, one cycle before the flag
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			result_r <= '0;
		end else if (state_r == lcm_pkg::ST_LATCH) begin
			result_r <= cur_code;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt and configuration registers

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			int_flag_r   <= 1'b0;
			int_mask_r   <= lcm_pkg::INT_MASK_RST;
			dither_en_r  <= lcm_pkg::DITHER_RST;
			fixed_freq_r <= lcm_pkg::FIXED_RST;
			ramp_code_r  <= {4{lcm_pkg::RAMP_RST}};
		end else begin
			// Set beats a clear landing in the same cycle
			int_flag_r <= flag_set || (int_flag_r && !flag_clr);
			if (wr_mask) begin
				int_mask_r <= wdata[lcm_pkg::MEAS_READY_BIT];
			end
			if (wr_cfg) begin
				dither_en_r <= wdata[lcm_pkg::DITHER_EN_BIT];
			end
			if (wr_fixed) begin
				fixed_freq_r <= wdata[3:0];
			end
			if (wr_r01) begin
				ramp_code_r[0] <= wdata[lcm_pkg::RAMP_LO_LSB +: 3];
				ramp_code_r[1] <= wdata[lcm_pkg::RAMP_HI_LSB +: 3];
			end
			if (wr_r23) begin
				ramp_code_r[2] <= wdata[lcm_pkg::RAMP_LO_LSB +: 3];
				ramp_code_r[3] <= wdata[lcm_pkg::RAMP_HI_LSB +: 3];
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			core_pwm_r <= 4'hf;
			irq_n_r    <= 1'b1;
			rd_data_r  <= 8'h00;
			ma_r       <= '0;
			busy_r     <= 1'b0;
		end else begin
			core_pwm_r <= core_pwm_nxt;
			irq_n_r    <= !(int_flag_r && !int_mask_r);
			if (i_reg_req.rd) begin
				rd_data_r <= rd_mux;
			end
			ma_r   <= lcm_pkg::scale_ma(result_r);
			busy_r <= (state_nxt != lcm_pkg::ST_IDLE);
		end
	end

	assign o_rd_data             = rd_data_r;
	assign o_interrupt_request_n = irq_n_r;
	assign o_core_pwm            = core_pwm_r;
	assign o_load_current_ma     = ma_r;
	assign o_meas_busy           = busy_r;

	////////////////////////////////////////////////////////////////////////////////
	// Switching timing and ramp decode

	phase_interleaver #(
		.PERIOD (lcm_pkg::SW_PERIOD_CYC),
		.DITHER (lcm_pkg::DITHER_CYC)
	) u_phase (
		.i_clk         (i_clk),
		.i_sys_rst     (i_sys_rst),
		.i_dither_en   (dither_en_r),
		.o_phase_start (o_core_phase_start)
	);

	ramp_rate_table u_ramp (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_code    (ramp_code_r),
		.o_rate    (o_ramp_rate)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_complete;
		(state_r == lcm_pkg::ST_LATCH) && !launch;
	endsequence

	sequence s_publish;
		(result_r == $past(cur_code)) && !int_flag_r ##1 int_flag_r;
	endsequence

	a_write_launches: assert property (launch |=>
		(state_r == lcm_pkg::ST_MEASURE) && (core_sel_r == $past(new_core)))
		else $error("core select write did not start a measurement");

	a_pfm_duration: assert property ((launch && !new_core_pwm) |=>
		(tmr_r == PFM_LOAD))
		else $error("PFM measurement not given the long duration");

	a_pwm_duration: assert property ((launch && new_core_pwm) |=>
		(tmr_r == PWM_LOAD))
		else $error("PWM measurement not given the short duration");

	a_forced_fixed: assert property ((measuring && $past(measuring)
		&& $stable(core_sel_r)) |-> core_pwm_r[core_sel_r])
		else $error("measured core not held in fixed frequency");

	a_result_flag: assert property (s_complete |=> s_publish)
		else $error("result and ready flag not published in order");

	a_result_hold: assert property (measuring |=> $stable(result_r))
		else $error("result changed during a measurement");

	a_mask_blocks: assert property (int_mask_r |=> o_interrupt_request_n)
		else $error("masked flag raised the interrupt");

	a_irq_pending: assert property ((int_flag_r && !int_mask_r) |=>
		!o_interrupt_request_n)
		else $error("interrupt released with an unmasked flag pending");

	a_split_high: assert property ((i_reg_req.rd && addr == lcm_pkg::ADDR_RESULT_HIGH)
		|=> (o_rd_data == {6'h00, $past(result_r[9:8])}))
		else $error("high result register misplaced bits");

	a_split_low: assert property ((i_reg_req.rd && addr == lcm_pkg::ADDR_RESULT_LOW)
		|=> (o_rd_data == $past(result_r[7:0])))
		else $error("low result register misplaced bits");

	a_flag_set_wins: assert property (flag_set |=> int_flag_r)
		else $error("ready flag lost when set and clear met");

	a_irq_release: assert property (!int_flag_r |=> o_interrupt_request_n)
		else $error("interrupt held with no flag pending");

	// Busy must drop as soon as the sequencer rests, or a polling host waits forever
	a_busy_idle: assert property (((state_r == lcm_pkg::ST_IDLE) && !launch) |=>
		!o_meas_busy)
		else $error("busy still shown while the sequencer is idle");

	a_scale_ma: assert property (1'b1 |=>
		(o_load_current_ma == $past(result_r) * 15'h014))
		else $error("load current not scaled at 20 mA per count");

	for (genvar k = 0; k < 4; k++) begin : g_chk_mode
		a_auto_pfm: assert property ((!fixed_freq_r[k] && i_core_light_load[k]
			&& !(measuring && core_sel_r == 2'(k))
			&& !$past(i_sys_rst)) |=> !core_pwm_r[k])
			else $error("light-load core not in PFM under auto mode");
	end

endmodule : load_current_monitor

// ===== bench/lcm_host.sv
module lcm_host (
	input  wire logic              i_clk,
	input  wire logic [7:0]        i_rd_data,
	output lcm_pkg::reg_req_t      o_reg_req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial o_reg_req = '0;

	////////////////////////////////////////////////////////////////////////////////
	// A released bus shows inverted address and data, so a stale value never decodes by luck
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_clk);
		o_reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge i_clk);
		o_reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
		#1;
		d = i_rd_data;
	endtask : reg_read

endmodule : lcm_host

// ===== bench/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int PFM_N = 40;
	localparam int PWM_N = 8;

	typedef struct packed {
		logic [1:0] core;
		logic       light;
		logic [9:0] code;
	} row_t;

	logic                              clk          = 1'b0;
	logic                              rst          = 1'b1;
	logic [3:0]                        light        = 4'h0;
	logic [3:0][9:0]                   codes        = '0;
	lcm_pkg::reg_req_t                 req;
	logic [7:0]                        rd_data;
	logic                              irq_n;
	logic [3:0]                        pwm;
	logic [3:0]                        phase;
	logic [3:0][lcm_pkg::RATE_W-1:0]   rate;
	logic [lcm_pkg::MA_W-1:0]          ma;
	logic                              busy;
	int                                err_count    = 0;
	int                                total_checks = 0;
	int                                cycles       = 0;
	row_t                              rows [4]     = '{'{2'h0, 1'b1, 10'h3ff},
		'{2'h1, 1'b0, 10'h000}, '{2'h2, 1'b1, 10'h155}, '{2'h3, 1'b0, 10'h2aa}};
	logic [11:0]                       rates [8]    = '{12'hbb8, 12'h5dc, 12'h3e8,
		12'h2ee, 12'h17c, 12'h0be, 12'h05e, 12'h028};

	always #2.5 clk = ~clk;

	lcm_host u_host (
		.i_clk     (clk),
		.i_rd_data (rd_data),
		.o_reg_req (req)
	);

	load_current_monitor #(
		.MEAS_PFM_CYCLES (PFM_N),
		.MEAS_PWM_CYCLES (PWM_N)
	) u_dut (
		.i_clk                 (clk),
		.i_sys_rst             (rst),
		.i_reg_req             (req),
		.i_core_light_load     (light),
		.i_core_current_code   (codes),
		.o_rd_data             (rd_data),
		.o_interrupt_request_n (irq_n),
		.o_core_pwm            (pwm),
		.o_core_phase_start    (phase),
		.o_ramp_rate           (rate),
		.o_load_current_ma     (ma),
		.o_meas_busy           (busy)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wait_done(input logic [1:0] core, output int cyc);
		#1;
		cyc = 0;
		while (busy === 1'b1 && cyc < 20000) begin
			if (cyc == 2) check(pwm[core], 1'b1);
			cyc++;
			@(posedge clk);
			#1;
		end
	endtask : wait_done

	// Cycles from a start pulse of core a to the next start pulse of core b
	task automatic gap(input int a, input int b, output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (phase[a] !== 1'b1 && n < 200);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (phase[b] !== 1'b1 && n < 200);
	endtask : gap

	// Whole run needs under two thousand cycles; far above that means a hang
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int         cyc;
		int         n_dith;
		logic [7:0] d;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check(irq_n, 1'b1);
		check(busy, 1'b0);
		check(ma, 15'h0000);
		for (int a = 0; a < 10; a++) begin
			u_host.reg_read((a == 9) ? 8'h7f : 8'(a), d);
			check(d, 8'h00);
		end
		foreach (rows[i]) begin
			@(posedge clk);
			light <= {4{rows[i].light}};
			for (int k = 0; k < 4; k++)
				codes[k] <= (k == rows[i].core) ? rows[i].code : ~rows[i].code;
			@(posedge clk);
			u_host.reg_write(8'h00, {6'h00, rows[i].core});
			wait_done(rows[i].core, cyc);
			check(cyc, (rows[i].light ? PFM_N : PWM_N) + 2);
			check(ma, 15'(rows[i].code) * 15'h0014);
			u_host.reg_read(8'h01, d);
			check(d, rows[i].code[7:0]);
			u_host.reg_read(8'h02, d);
			check(d, {6'h00, rows[i].code[9:8]});
			u_host.reg_read(8'h00, d);
			check(d, {6'h00, rows[i].core});
			u_host.reg_read(8'h03, d);
			check(d, 8'h01);
			check(irq_n, 1'b0);
			u_host.reg_write(8'h03, 8'h01);
			u_host.reg_read(8'h03, d);
			check(d, 8'h00);
			check(irq_n, 1'b1);
		end
		for (int c = 0; c < 8; c++) begin
			u_host.reg_write(8'h07, {1'b0, 3'(7 - c), 1'b0, 3'(c)});
			u_host.reg_write(8'h08, {1'b0, 3'(c), 1'b0, 3'(7 - c)});
			repeat (2) @(posedge clk);
			#1;
			check(rate[0], rates[c]);
			check(rate[1], rates[7 - c]);
			check(rate[2], rates[7 - c]);
			check(rate[3], rates[c]);
		end
		u_host.reg_write(8'h04, 8'h01);
		u_host.reg_write(8'h00, 8'h02);
		wait_done(2'h2, cyc);
		repeat (3) @(posedge clk);
		#1;
		check(irq_n, 1'b1);
		u_host.reg_read(8'h03, d);
		check(d, 8'h01);
		u_host.reg_write(8'h04, 8'h00);
		repeat (2) @(posedge clk);
		#1;
		check(irq_n, 1'b0);
		u_host.reg_write(8'h03, 8'h01);
		@(posedge clk);
		light <= 4'hf;
		codes <= {10'h123, 10'h0c8, 10'h2aa, 10'h3c3};
		repeat (2) @(posedge clk);
		u_host.reg_write(8'h00, 8'h00);
		repeat (6) @(posedge clk);
		u_host.reg_read(8'h01, d);
		check(d, 8'h55);
		u_host.reg_write(8'h00, 8'h01);
		wait_done(2'h1, cyc);
		check(cyc, PFM_N + 2);
		check(ma, 15'h3548);
		u_host.reg_write(8'h03, 8'h01);
		@(posedge clk);
		light <= 4'h5;
		repeat (3) @(posedge clk);
		#1;
		check(pwm, 4'ha);
		u_host.reg_write(8'h06, 8'h0f);
		repeat (2) @(posedge clk);
		#1;
		check(pwm, 4'hf);
		u_host.reg_write(8'h06, 8'h00);
		gap(0, 1, cyc);
		check(cyc, 16);
		gap(2, 3, cyc);
		check(cyc, 16);
		gap(0, 0, cyc);
		check(cyc, 66);
		u_host.reg_write(8'h05, 8'h01);
		n_dith = 0;
		for (int p = 0; p < 6; p++) begin
			gap(0, 0, cyc);
			check(cyc >= 63 && cyc <= 69, 1'b1);
			n_dith += (cyc != 66) ? 1 : 0;
		end
		// A period stuck at the centre would pass the band check alone
		check(n_dith > 0, 1'b1);
		// Reset in mid-measurement must leave nothing of the aborted run
		u_host.reg_write(8'h00, 8'h03);
		repeat (4) @(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check(busy, 1'b0);
		check(irq_n, 1'b1);
		check(ma, 15'h0000);
		check(pwm, 4'ha);
		check(rate[3], rates[0]);
		u_host.reg_read(8'h00, d);
		check(d, 8'h00);
		report_and_stop();
	end

endmodule : tb
